// *** core/sgs_arb_if.sv ***
`timescale 1ns/1ps
interface sgs_arb_if;
  logic [2:0] req;
  sgs_pkg::sgs_group_t cfg_group;
  sgs_pkg::sgs_group_t target;

  modport main (output req, output cfg_group, input target);
  modport arb (input req, input cfg_group, output target);
endinterface

// *** core/sgs_group_arb.sv ***
`timescale 1ns/1ps
module sgs_group_arb (
  sgs_arb_if.arb sel
);

  // highest request wins; none falls back to the configured group
  always_comb begin
    if (sel.req[2]) begin
      sel.target = 2'h3;
    end else if (sel.req[1]) begin
      sel.target = 2'h2;
    end else if (sel.req[0]) begin
      sel.target = 2'h1;
    end else begin
      sel.target = sel.cfg_group;
    end
  end

endmodule // sgs_group_arb

// *** core/sgs_pkg.sv ***
package sgs_pkg;

  typedef logic [1:0] sgs_group_t;

  typedef enum logic [1:0] {
    SGS_RUN  = 2'b01,
    SGS_HOLD = 2'b10
  } sgs_state_e;

endpackage

// *** core/sgs_regs.svh ***
`ifndef SGS_REGS_SVH
`define SGS_REGS_SVH

// byte offsets on the register bus
`define SGS_CTRL_OFS      8'h00
`define SGS_STATUS_OFS    8'h04
`define SGS_IRQ_STAT_OFS  8'h08
`define SGS_IRQ_MASK_OFS  8'h0c
`define SGS_EVENT_OFS     8'h10
`define SGS_SET_BASE_OFS  8'h20
`define SGS_SET_LAST_OFS  8'h2c

// control fields
`define SGS_CTRL_CFG_LSB  0
`define SGS_CTRL_EDIT_LSB 2
`define SGS_CTRL_BRK_BIT  5
`define SGS_CTRL_OC_BIT   6

// edit selector code that points at the active group
`define SGS_EDIT_ACTIVE   3'h0

// interrupt status bits
`define SGS_IRQ_CHANGE    0
`define SGS_IRQ_DEFER     1

// reset values
`define SGS_CFG_RST       2'h0
`define SGS_GROUP_NUM_RST 3'h1
`define SGS_SET_RST       32'h0000_0000

`endif

// *** core/sgs_top.sv ***
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "sgs_regs.svh"
module sgs_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // discrete inputs
  input wire logic [2:0] grp_req,
  input wire logic breaker_closed,
  input wire logic oc_pickup,
  // group outputs
  output logic [2:0] group_num,
  output logic [31:0] active_setting,
  output logic event_valid,
  output logic [2:0] event_group,
  output logic irq
);

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] to_num(input sgs_pkg::sgs_group_t g);
    return {1'b0, g} + 3'h1;
  endfunction

  // input synchronisers: first stage read only by second
  logic [4:0] sync1;
  logic [4:0] sync2;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {oc_pickup, breaker_closed, grp_req};
      sync2 <= sync1;
    end
  end
  logic [2:0] req_s;
  logic brk_s;
  logic oc_s;
  assign req_s = sync2[2:0];
  assign brk_s = sync2[3];
  assign oc_s = sync2[4];

  sgs_arb_if sel ();
  sgs_group_arb u_arb (
    .sel(sel)
  );

  // register state
  sgs_pkg::sgs_group_t cfg_group;
  logic [2:0] edit_sel;
  logic brk_hold_en;
  logic oc_hold_en;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [15:0] event_count;
  logic [31:0] set_mem [4];
  logic [31:0] next_readdata;
  logic next_waitrequest;
  sgs_pkg::sgs_group_t next_cfg_group;
  logic [2:0] next_edit_sel;
  logic next_brk_hold_en;
  logic next_oc_hold_en;
  logic [1:0] next_irq_stat;
  logic [1:0] next_irq_mask;
  logic [15:0] next_event_count;
  logic [31:0] next_set_mem [4];
  logic next_irq;

  // group state
  sgs_pkg::sgs_state_e state;
  sgs_pkg::sgs_state_e next_state;
  sgs_pkg::sgs_group_t active;
  sgs_pkg::sgs_group_t next_active;
  logic [2:0] next_group_num;
  logic [31:0] next_active_setting;
  logic next_event_valid;
  logic [2:0] next_event_group;
  logic hold;
  logic changed;
  logic deferred;

  assign sel.req = req_s;
  assign sel.cfg_group = cfg_group;

  logic wr_acc;
  assign wr_acc = avs_write & ~avs_waitrequest;

  // a change is held off while a hold condition stands
  always_comb begin
    hold = 1'b0;
    if (brk_hold_en && !brk_s && sel.target < active) begin
      hold = 1'b1;
    end
    if (oc_hold_en && oc_s) begin
      hold = 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    next_active = active;
    deferred = 1'b0;
    unique case (state)
      sgs_pkg::SGS_RUN: begin
        if (sel.target != active) begin
          if (hold) begin
            next_state = sgs_pkg::SGS_HOLD;
            deferred = 1'b1;
          end else begin
            next_active = sel.target;
          end
        end
      end
      sgs_pkg::SGS_HOLD: begin
        if (sel.target == active) begin
          next_state = sgs_pkg::SGS_RUN;
        end else if (!hold) begin
          next_active = sel.target;
          next_state = sgs_pkg::SGS_RUN;
        end
      end
    endcase
    changed = next_active != active;
    next_group_num = to_num(next_active);
    next_active_setting = set_mem[active];
    next_event_valid = changed;
    next_event_group = changed ? next_group_num : event_group;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= sgs_pkg::SGS_RUN;
      active <= `SGS_CFG_RST;
      group_num <= `SGS_GROUP_NUM_RST;
      active_setting <= `SGS_SET_RST;
      event_valid <= 1'b0;
      event_group <= `SGS_GROUP_NUM_RST;
    end else begin
      state <= next_state;
      active <= next_active;
      group_num <= next_group_num;
      active_setting <= next_active_setting;
      event_valid <= next_event_valid;
      event_group <= next_event_group;
    end
  end

  // bus: one wait cycle, then the access is taken with waitrequest low
  always_comb begin
    logic [31:0] ctrl_w;
    ctrl_w = be_merge({25'h0, oc_hold_en, brk_hold_en, edit_sel, cfg_group},
                      avs_writedata, avs_byteenable);
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    next_cfg_group = cfg_group;
    next_edit_sel = edit_sel;
    next_brk_hold_en = brk_hold_en;
    next_oc_hold_en = oc_hold_en;
    next_irq_mask = irq_mask;
    next_event_count = changed ? event_count + 16'h0001 : event_count;
    for (int g = 0; g < 4; g++) begin
      next_set_mem[g] = set_mem[g];
    end
    next_irq_stat = irq_stat;
    if ((avs_read || avs_write) && avs_waitrequest) begin
      next_waitrequest = 1'b0;
      next_readdata = 32'h0000_0000;
      if (avs_read) begin
        unique case (avs_address)
          `SGS_CTRL_OFS: next_readdata = {25'h0, oc_hold_en, brk_hold_en,
                                          edit_sel, cfg_group};
          `SGS_STATUS_OFS: next_readdata = {22'h0, oc_s, brk_s, req_s,
                                            state == sgs_pkg::SGS_HOLD,
                                            1'b0, group_num};
          `SGS_IRQ_STAT_OFS: next_readdata = {30'h0, irq_stat};
          `SGS_IRQ_MASK_OFS: next_readdata = {30'h0, irq_mask};
          `SGS_EVENT_OFS: next_readdata = {13'h0, event_group, event_count};
          8'h20, 8'h24, 8'h28, 8'h2c:
            next_readdata = set_mem[avs_address[3:2]];
          default: next_readdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr_acc) begin
      unique case (avs_address)
        `SGS_CTRL_OFS: begin
          next_edit_sel = ctrl_w[`SGS_CTRL_EDIT_LSB +: 3];
          next_brk_hold_en = ctrl_w[`SGS_CTRL_BRK_BIT];
          next_oc_hold_en = ctrl_w[`SGS_CTRL_OC_BIT];
          // group field only counts when editing the active group
          if (ctrl_w[`SGS_CTRL_EDIT_LSB +: 3] == `SGS_EDIT_ACTIVE) begin
            next_cfg_group = ctrl_w[`SGS_CTRL_CFG_LSB +: 2];
          end
        end
        `SGS_IRQ_STAT_OFS: next_irq_stat = irq_stat & ~avs_writedata[1:0];
        `SGS_IRQ_MASK_OFS: next_irq_mask = avs_writedata[1:0];
        8'h20, 8'h24, 8'h28, 8'h2c:
          next_set_mem[avs_address[3:2]] =
            be_merge(set_mem[avs_address[3:2]], avs_writedata,
                     avs_byteenable);
        default: next_irq_mask = irq_mask;
      endcase
    end
    // set wins over a clear in the same cycle
    if (changed) begin
      next_irq_stat[`SGS_IRQ_CHANGE] = 1'b1;
    end
    if (deferred) begin
      next_irq_stat[`SGS_IRQ_DEFER] = 1'b1;
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      cfg_group <= `SGS_CFG_RST;
      edit_sel <= `SGS_EDIT_ACTIVE;
      brk_hold_en <= 1'b0;
      oc_hold_en <= 1'b0;
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
      event_count <= 16'h0000;
      irq <= 1'b0;
      for (int g = 0; g < 4; g++) begin
        set_mem[g] <= `SGS_SET_RST;
      end
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
      cfg_group <= next_cfg_group;
      edit_sel <= next_edit_sel;
      brk_hold_en <= next_brk_hold_en;
      oc_hold_en <= next_oc_hold_en;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      event_count <= next_event_count;
      irq <= next_irq;
      for (int g = 0; g < 4; g++) begin
        set_mem[g] <= next_set_mem[g];
      end
    end
  end

  // checks
  reset_group_a: assert property (@(posedge sys_clk)
    $fell(reset) |-> group_num == 3'h1 && active == 2'h0)
    else $error("group not 1 after reset");

  stay_put_a: assert property (@(posedge sys_clk)
    disable iff (reset) sel.target == active |=> $stable(active))
    else $error("active group moved with no request");

  cfg_write_a: assert property (@(posedge sys_clk)
    disable iff (reset)
    wr_acc && avs_address == `SGS_CTRL_OFS && avs_byteenable[0] &&
    avs_writedata[4:2] == 3'h0 && req_s == 3'h0 && !oc_hold_en &&
    !brk_hold_en
    |=> cfg_group == $past(avs_writedata[1:0]) ##1 active == cfg_group)
    else $error("configured group write did not take");

  setting_route_a: assert property (@(posedge sys_clk)
    disable iff (reset) ##1 active_setting == $past(set_mem[active]))
    else $error("wrong group settings routed");

  indicator_a: assert property (@(posedge sys_clk)
    disable iff (reset) group_num == to_num(active))
    else $error("indicator disagrees with active group");

  prio_high_a: assert property (@(posedge sys_clk)
    disable iff (reset) req_s[2] |-> sel.target == 2'h3)
    else $error("group 4 request lost priority");

  fall_back_a: assert property (@(posedge sys_clk)
    disable iff (reset) req_s == 3'b011 |-> sel.target == 2'h2)
    else $error("no fallback to group 3");

  release_all_a: assert property (@(posedge sys_clk)
    disable iff (reset) req_s == 3'h0 |-> sel.target == cfg_group)
    else $error("no return to configured group");

  event_log_a: assert property (@(posedge sys_clk)
    disable iff (reset) active != $past(active) |->
    event_valid && event_group == group_num)
    else $error("group change not logged");

  brk_defer_a: assert property (@(posedge sys_clk)
    disable iff (reset) brk_hold_en && !brk_s && sel.target < active
    |=> $stable(active))
    else $error("lower group taken with breaker open");

  oc_defer_a: assert property (@(posedge sys_clk)
    disable iff (reset) oc_hold_en && oc_s |=> $stable(active))
    else $error("group changed during pickup");

  cfg_follow_a: assert property (@(posedge sys_clk)
    disable iff (reset) req_s == 3'h0 && !hold |=> active == $past(cfg_group))
    else $error("active does not follow configuration");

endmodule // sgs_top

// *** testbench/sgs_pins_model.sv ***
`timescale 1ns/1ps
module sgs_pins_model (
  // clock
  input wire logic sys_clk,
  // wanted pin states from the bench
  input wire logic [2:0] want_req,
  input wire logic want_brk,
  input wire logic [31:0] current,
  // active group threshold from the block
  input wire logic [31:0] threshold,
  // discrete pins
  output logic [2:0] grp_req,
  output logic breaker_closed,
  output logic oc_pickup
);
  initial begin
    grp_req = 3'h0;
    breaker_closed = 1'b1;
    oc_pickup = 1'b0;
  end
  // pins move only after an edge, like a real contact bank
  always @(posedge sys_clk) begin
    grp_req <= want_req;
    breaker_closed <= want_brk;
    // element compares against the active group's threshold
    oc_pickup <= current > threshold;
  end
endmodule // sgs_pins_model

// *** testbench/tb_sgs_top.sv ***
`timescale 1ns/1ps
`include "sgs_regs.svh"
`define CHK(nm, e, g) begin check_count++; \
  if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g); end end
module tb_sgs_top;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [2:0] grp_req;
  logic breaker_closed;
  logic oc_pickup;
  logic [2:0] group_num;
  logic [31:0] active_setting;
  logic event_valid;
  logic [2:0] event_group;
  logic irq;
  logic [2:0] want_req = 3'h0;
  logic want_brk = 1'b1;
  logic [31:0] current = 32'h0;
  logic [31:0] rdat;
  int error_cnt = 0;
  int check_count = 0;
  int ev_cnt = 0;

  sgs_top uut (.sys_clk(sys_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .grp_req(grp_req),
    .breaker_closed(breaker_closed), .oc_pickup(oc_pickup),
    .group_num(group_num), .active_setting(active_setting),
    .event_valid(event_valid), .event_group(event_group), .irq(irq));

  sgs_pins_model pins (.sys_clk(sys_clk), .want_req(want_req),
    .want_brk(want_brk), .current(current), .threshold(active_setting),
    .grp_req(grp_req), .breaker_closed(breaker_closed),
    .oc_pickup(oc_pickup));

  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (event_valid === 1'b1) ev_cnt <= ev_cnt + 1;
  end

  // hold the request until waitrequest is seen low, release after
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge sys_clk);
    end
    if (n >= 50) error_cnt++;
    // taken at the edge that sees waitrequest low, released right after
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task pins_set(input logic [2:0] r, input logic b, input logic [31:0] c);
    @(posedge sys_clk);
    want_req <= r;
    want_brk <= b;
    current <= c;
  endtask

  // bounded wait for a group, then count the recorder entries
  task wait_grp(input logic [2:0] g, input int ev);
    int n;
    int e0;
    n = 0;
    e0 = ev_cnt;
    while (group_num !== g && n < 20) begin
      n++;
      @(negedge sys_clk);
    end
    repeat (3) @(negedge sys_clk);
    `CHK("group_num", g, group_num)
    `CHK("event count", ev, ev_cnt - e0)
    if (ev > 0) `CHK("event_group", g, event_group)
  endtask

  task t_reset;
    `CHK("group after reset", 3'h1, group_num)
    bus(1'b0, `SGS_STATUS_OFS, 32'h0);
    `CHK("status group", 3'h1, rdat[2:0])
    bus(1'b0, 8'h40, 32'h0);
    `CHK("unmapped read", 32'h0, rdat)
  endtask

  task t_cfg;
    int seq[4];
    seq = '{2, 3, 4, 1};
    for (int g = 1; g <= 4; g++)
      bus(1'b1, 8'(`SGS_SET_BASE_OFS + 4 * (g - 1)), 32'(g * 'h100));
    foreach (seq[i]) begin
      bus(1'b1, `SGS_CTRL_OFS, 32'(seq[i] - 1));
      wait_grp(3'(seq[i]), 1);
      `CHK("active setting", 32'(seq[i] * 'h100), active_setting)
    end
    // edit selector away from the active group must not switch
    bus(1'b1, `SGS_CTRL_OFS, 32'h0000_000b);
    wait_grp(3'h1, 0);
  endtask

  task t_req;
    logic [2:0] r[6];
    logic [2:0] e[6];
    logic [15:0] ev0;
    r = '{3'h1, 3'h3, 3'h7, 3'h3, 3'h1, 3'h0};
    e = '{3'h2, 3'h3, 3'h4, 3'h3, 3'h2, 3'h1};
    bus(1'b1, `SGS_IRQ_STAT_OFS, 32'h3);
    bus(1'b1, `SGS_IRQ_MASK_OFS, 32'h1);
    bus(1'b0, `SGS_EVENT_OFS, 32'h0);
    ev0 = rdat[15:0];
    foreach (r[i]) begin
      pins_set(r[i], 1'b1, 32'h0);
      wait_grp(e[i], 1);
    end
    bus(1'b0, `SGS_EVENT_OFS, 32'h0);
    `CHK("event log count", 16'h0006, rdat[15:0] - ev0)
    `CHK("event log group", 3'h1, rdat[18:16])
    `CHK("irq raised", 1'b1, irq)
    bus(1'b1, `SGS_IRQ_STAT_OFS, 32'h1);
    repeat (2) @(negedge sys_clk);
    `CHK("irq cleared", 1'b0, irq)
    bus(1'b1, `SGS_IRQ_MASK_OFS, 32'h0);
    bus(1'b1, `SGS_CTRL_OFS, 32'h3);
    wait_grp(3'h4, 1);
    `CHK("irq masked", 1'b0, irq)
    pins_set(3'h1, 1'b1, 32'h0);
    wait_grp(3'h2, 1);
    pins_set(3'h0, 1'b1, 32'h0);
    wait_grp(3'h4, 1);
    bus(1'b1, `SGS_CTRL_OFS, 32'h0);
    wait_grp(3'h1, 1);
  endtask

  task t_hold;
    bus(1'b1, `SGS_CTRL_OFS, 32'h20);
    pins_set(3'h0, 1'b0, 32'h0);
    pins_set(3'h1, 1'b0, 32'h0);
    wait_grp(3'h2, 1);
    pins_set(3'h0, 1'b0, 32'h0);
    repeat (10) @(negedge sys_clk);
    wait_grp(3'h2, 0);
    bus(1'b0, `SGS_IRQ_STAT_OFS, 32'h0);
    `CHK("deferred flag", 1'b1, rdat[1])
    bus(1'b0, `SGS_STATUS_OFS, 32'h0);
    `CHK("hold pending", 1'b1, rdat[4])
    pins_set(3'h0, 1'b1, 32'h0);
    wait_grp(3'h1, 1);
    bus(1'b1, `SGS_CTRL_OFS, 32'h40);
    pins_set(3'h1, 1'b1, 32'h0);
    wait_grp(3'h2, 1);
    pins_set(3'h1, 1'b1, 32'h250);
    pins_set(3'h0, 1'b1, 32'h250);
    repeat (10) @(negedge sys_clk);
    wait_grp(3'h2, 0);
    pins_set(3'h0, 1'b1, 32'h0);
    wait_grp(3'h1, 1);
  endtask

  task complete_run;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 5000);
    error_cnt++;
    complete_run;
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    t_reset;
    t_cfg;
    t_req;
    t_hold;
    complete_run;
  end
endmodule // tb_sgs_top
